// ===== pkg/bmsr_pkg.sv
/*
  boot mode select and reset package: strap pin positions, boot modes,
  core and test port states, instruction codes, shared decode function.
  assumes a single 250 mhz clock and nothing imported by users.
*/
package bmsr_pkg;

  // positions of the asynchronous pins inside the synchroniser vector
  localparam int PIN_RESET_N = 0;
  localparam int PIN_EPROM   = 1;
  localparam int PIN_LINK    = 2;
  localparam int PIN_SEL_N   = 3;
  localparam int PIN_TCK     = 4;
  localparam int PIN_TMS     = 5;
  localparam int PIN_TDI     = 6;
  localparam int PIN_TRST_N  = 7;
  localparam int PIN_COUNT   = 8;
  localparam logic [PIN_COUNT-1:0] SYNC_RESET = 8'h00;

  localparam int EPROM_WIDTH = 8;  // boot eprom is byte wide
  localparam int BSR_WIDTH   = 8;  // boundary capture bits
  localparam int IR_WIDTH    = 4;
  localparam logic [IR_WIDTH-1:0] IR_CAPTURE = 4'h1;
  localparam logic [IR_WIDTH-1:0] IR_SAMPLE  = 4'h2;
  localparam logic [IR_WIDTH-1:0] IR_BYPASS  = 4'hf;

  typedef enum logic [1:0] {
    bmsr_mode_eprom, bmsr_mode_host, bmsr_mode_none, bmsr_mode_reserved
  } bmsr_mode_t;

  typedef enum logic [1:0] {st_held, st_boot, st_run} bmsr_core_t;

  typedef enum logic [3:0] {
    tap_reset, tap_idle, tap_sel_dr, tap_cap_dr, tap_sh_dr, tap_ex1_dr,
    tap_pau_dr, tap_ex2_dr, tap_upd_dr, tap_sel_ir, tap_cap_ir, tap_sh_ir,
    tap_ex1_ir, tap_pau_ir, tap_ex2_ir, tap_upd_ir
  } bmsr_tap_t;

  // strap decode: eprom strap wins, then link strap gives reserved, otherwise boot select input picks
  function automatic bmsr_mode_t bmsr_decode(input logic eprom_strap,
                                             input logic link_strap,
                                             input logic select_n);
    if (eprom_strap)
      return bmsr_mode_eprom;
    else if (link_strap)
      return bmsr_mode_reserved;
    else if (select_n)
      return bmsr_mode_host;
    else
      return bmsr_mode_none;
  endfunction : bmsr_decode

endpackage : bmsr_pkg

// ===== pkg/bmsr_scan_if.sv
/*
  carrier between the boot core and its test port engine.
  assumes all signals live on the core clock; tck appears only as enables.
*/
interface bmsr_scan_if;
  logic                           tck_rise;
  logic                           tck_fall;
  logic                           tms;
  logic                           tdi;
  logic                           trst_n;
  logic [bmsr_pkg::BSR_WIDTH-1:0] capture_bits;
  logic                           tdo;
  logic                           tdo_oe;
  logic                           in_reset;

  modport tap (input tck_rise, tck_fall, tms, tdi, trst_n, capture_bits,
               output tdo, tdo_oe, in_reset);
  modport core (output tck_rise, tck_fall, tms, tdi, trst_n, capture_bits,
                input tdo, tdo_oe, in_reset);
endinterface : bmsr_scan_if

// ===== hw/bmsr_tap.sv
/*
  test port engine: state machine, instruction register, bypass and
  boundary capture chain.
  assumes tck, tms, tdi and trst_n already synchronised by the core.
*/
module bmsr_tap
(
  input wire logic  clock,
  input wire logic  rst,
  bmsr_scan_if.tap  scan
);

  bmsr_pkg::bmsr_tap_t                 st_reg, st_next;
  logic [bmsr_pkg::IR_WIDTH-1:0]       ir_sh_reg, ir_sh_next;
  logic [bmsr_pkg::IR_WIDTH-1:0]       ir_reg, ir_next;
  logic [bmsr_pkg::BSR_WIDTH-1:0]      dr_reg, dr_next;
  logic                                byp_reg, byp_next;
  logic                                tdo_reg, tdo_next;
  logic                                oe_reg, oe_next;

  // standard sixteen state walk, steered by tms
  function automatic bmsr_pkg::bmsr_tap_t step(input bmsr_pkg::bmsr_tap_t s,
                                               input logic m);
    case (s)
      bmsr_pkg::tap_reset:  return m ? bmsr_pkg::tap_reset  : bmsr_pkg::tap_idle;
      bmsr_pkg::tap_idle:   return m ? bmsr_pkg::tap_sel_dr : bmsr_pkg::tap_idle;
      bmsr_pkg::tap_sel_dr: return m ? bmsr_pkg::tap_sel_ir : bmsr_pkg::tap_cap_dr;
      bmsr_pkg::tap_cap_dr: return m ? bmsr_pkg::tap_ex1_dr : bmsr_pkg::tap_sh_dr;
      bmsr_pkg::tap_sh_dr:  return m ? bmsr_pkg::tap_ex1_dr : bmsr_pkg::tap_sh_dr;
      bmsr_pkg::tap_ex1_dr: return m ? bmsr_pkg::tap_upd_dr : bmsr_pkg::tap_pau_dr;
      bmsr_pkg::tap_pau_dr: return m ? bmsr_pkg::tap_ex2_dr : bmsr_pkg::tap_pau_dr;
      bmsr_pkg::tap_ex2_dr: return m ? bmsr_pkg::tap_upd_dr : bmsr_pkg::tap_sh_dr;
      bmsr_pkg::tap_upd_dr: return m ? bmsr_pkg::tap_sel_dr : bmsr_pkg::tap_idle;
      bmsr_pkg::tap_sel_ir: return m ? bmsr_pkg::tap_reset  : bmsr_pkg::tap_cap_ir;
      bmsr_pkg::tap_cap_ir: return m ? bmsr_pkg::tap_ex1_ir : bmsr_pkg::tap_sh_ir;
      bmsr_pkg::tap_sh_ir:  return m ? bmsr_pkg::tap_ex1_ir : bmsr_pkg::tap_sh_ir;
      bmsr_pkg::tap_ex1_ir: return m ? bmsr_pkg::tap_upd_ir : bmsr_pkg::tap_pau_ir;
      bmsr_pkg::tap_pau_ir: return m ? bmsr_pkg::tap_ex2_ir : bmsr_pkg::tap_pau_ir;
      bmsr_pkg::tap_ex2_ir: return m ? bmsr_pkg::tap_upd_ir : bmsr_pkg::tap_sh_ir;
      bmsr_pkg::tap_upd_ir: return m ? bmsr_pkg::tap_sel_dr : bmsr_pkg::tap_idle;
      default:              return bmsr_pkg::tap_reset;
    endcase
  endfunction : step

  // next values; trst_n overrides everything, shifting on tck rise
  always_comb
  begin
    st_next    = st_reg;
    ir_sh_next = ir_sh_reg;
    ir_next    = ir_reg;
    dr_next    = dr_reg;
    byp_next   = byp_reg;
    tdo_next   = tdo_reg;
    oe_next    = oe_reg;
    if (!scan.trst_n)
    begin
      st_next = bmsr_pkg::tap_reset;  // R13
      ir_next = bmsr_pkg::IR_BYPASS;
      oe_next = 1'b0;
    end
    else
    begin
      if (scan.tck_rise)
      begin
        st_next = step(st_reg, scan.tms);  // R14
        case (st_reg)
          bmsr_pkg::tap_reset:  ir_next = bmsr_pkg::IR_BYPASS;
          bmsr_pkg::tap_cap_ir: ir_sh_next = bmsr_pkg::IR_CAPTURE;
          bmsr_pkg::tap_sh_ir:
            ir_sh_next = {scan.tdi, ir_sh_reg[bmsr_pkg::IR_WIDTH-1:1]};  // R15
          bmsr_pkg::tap_upd_ir: ir_next = ir_sh_reg;
          bmsr_pkg::tap_cap_dr:
          begin
            dr_next  = scan.capture_bits;
            byp_next = 1'b0;
          end
          bmsr_pkg::tap_sh_dr:
            if (ir_reg == bmsr_pkg::IR_BYPASS)
              byp_next = scan.tdi;
            else
              dr_next = {scan.tdi, dr_reg[bmsr_pkg::BSR_WIDTH-1:1]};  // R15
          default: ;
        endcase
      end
      // output changes on the falling edge, as scan chains expect
      if (scan.tck_fall)
      begin
        oe_next = (st_reg == bmsr_pkg::tap_sh_dr) || (st_reg == bmsr_pkg::tap_sh_ir);
        if (st_reg == bmsr_pkg::tap_sh_ir)
          tdo_next = ir_sh_reg[0];
        else if (ir_reg == bmsr_pkg::IR_BYPASS)
          tdo_next = byp_reg;
        else
          tdo_next = dr_reg[0];  // R15
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      st_reg    <= bmsr_pkg::tap_reset;
      ir_sh_reg <= bmsr_pkg::IR_CAPTURE;
      ir_reg    <= bmsr_pkg::IR_BYPASS;
      dr_reg    <= '0;
      byp_reg   <= 1'b0;
      tdo_reg   <= 1'b0;
      oe_reg    <= 1'b0;
    end
    else
    begin
      st_reg    <= st_next;
      ir_sh_reg <= ir_sh_next;
      ir_reg    <= ir_next;
      dr_reg    <= dr_next;
      byp_reg   <= byp_next;
      tdo_reg   <= tdo_next;
      oe_reg    <= oe_next;
    end
  end

  assign scan.tdo      = tdo_reg;
  assign scan.tdo_oe   = oe_reg;
  assign scan.in_reset = (st_reg == bmsr_pkg::tap_reset);

  a_tap_trst_reset: assert property (@(posedge clock) disable iff (rst)  // R13
    !scan.trst_n |=> (st_reg == bmsr_pkg::tap_reset) && !oe_reg)
    else $error("test port not in reset after trst");

  a_tdo_shift_only: assert property (@(posedge clock) disable iff (rst)  // R15
    $rose(oe_reg) |-> $past(st_reg) inside {bmsr_pkg::tap_sh_dr, bmsr_pkg::tap_sh_ir})
    else $error("tdo enabled outside a shift state");

endmodule : bmsr_tap

// ===== hw/bmsr_top.sv
/*
  boot mode select and reset: strap sampling, boot mode latch, boot chip
  select drive, core start sequencing and the test port pins.
  assumes one 250 mhz clock, synchronous active high rst, and that the
  boot loader and bus arbiter run on the same clock.
*/
// Contract
// R1: a high eprom boot strap selects loading the boot program from a byte wide eprom.
// R2: with that strap low, the link strap and the boot select input choose the mode.
// R3: in eprom mode with the link strap low the boot select pin drives the eprom select.
// R4: only the current bus master drives the boot select output.
// R5: both straps low and boot select low means no boot, run from external memory.
// R6: both straps low and boot select high means boot under host control.
// R7: the boot select pin can float only in eprom mode; elsewhere it is a plain input.
// R8: the board grounds the link strap and hardwires the other straps.
// R9: one instruction cycle runs per input clock period.
// R10: the clock source runs steadily and never stops or slows.
// R11: processor reset returns to a known state, then starts at the reset vector.
// R12: the system holds processor reset asserted at power up.
// R13: test reset resets the test state machine and must be pulsed or held low.
// R14: the scan logic runs from an asynchronous test clock and is steered by tms.
// R15: scan data enters on tdi and the scan path shifts out on tdo.
// R16: the board ties emulation status only to the emulator and leaves reserved pins open.
// R17: straps are sampled during reset and the mode is latched at release until next reset.
module bmsr_top #(
  parameter int                ADDR_WIDTH   = 32,
  parameter logic [ADDR_WIDTH-1:0] RESET_VECTOR = '0  // plain default, set per system
)
(
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  processor_reset_n,
  input  wire logic                  eprom_boot_strap,
  input  wire logic                  link_boot_strap,
  input  wire logic                  boot_memory_select_n_i,
  output logic                       boot_memory_select_n_o,
  output logic                       boot_memory_select_n_oe,
  input  wire logic                  bus_master,
  input  wire logic                  boot_select_float,
  input  wire logic                  boot_cs_request,
  input  wire logic                  boot_done,
  output bmsr_pkg::bmsr_mode_t       boot_mode,
  output logic                       boot_byte_wide,
  output logic                       boot_active,
  output logic                       core_held,
  output logic                       instr_enable,
  output logic                       exec_start,
  output logic [ADDR_WIDTH-1:0]      exec_address,
  input  wire logic                  tck,
  input  wire logic                  tms,
  input  wire logic                  tdi,
  input  wire logic                  trst_n,
  output logic                       tdo,
  output logic                       tdo_oe,
  output logic                       emulation_status_n,
  output logic                       reserved_output
);

  if (ADDR_WIDTH < 1 || ADDR_WIDTH > 32)
  begin : g_bad_width
    $error("bmsr_top: ADDR_WIDTH must be 1 to 32");
  end

  bmsr_scan_if scan ();

  logic [bmsr_pkg::PIN_COUNT-1:0] pins;
  logic [bmsr_pkg::PIN_COUNT-1:0] sync1_reg, sync1_next;
  logic [bmsr_pkg::PIN_COUNT-1:0] sync2_reg, sync2_next;
  logic                           tck_prev_reg, tck_prev_next;
  bmsr_pkg::bmsr_core_t           st_reg, st_next;
  bmsr_pkg::bmsr_mode_t           mode_reg, mode_next;
  logic                           link_reg, link_next;
  logic                           sel_o_reg, sel_o_next;
  logic                           sel_oe_reg, sel_oe_next;
  logic                           start_reg, start_next;
  logic [ADDR_WIDTH-1:0]          addr_reg, addr_next;
  logic                           held_pin;

  // every pin from the board or test probe passes two flops first
  assign pins = {trst_n, tdi, tms, tck, boot_memory_select_n_i,
                 link_boot_strap, eprom_boot_strap, processor_reset_n};

  always_comb
  begin
    sync1_next    = pins;
    sync2_next    = sync1_reg;
    tck_prev_next = sync2_reg[bmsr_pkg::PIN_TCK];
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sync1_reg    <= bmsr_pkg::SYNC_RESET;
      sync2_reg    <= bmsr_pkg::SYNC_RESET;
      tck_prev_reg <= 1'b0;
    end
    else
    begin
      sync1_reg    <= sync1_next;
      sync2_reg    <= sync2_next;
      tck_prev_reg <= tck_prev_next;
    end
  end

  assign held_pin = !sync2_reg[bmsr_pkg::PIN_RESET_N];

  // core sequencing: sample straps while held, latch once at release
  always_comb
  begin
    st_next     = st_reg;
    mode_next   = mode_reg;
    link_next   = link_reg;
    start_next  = 1'b0;
    addr_next   = addr_reg;
    sel_o_next  = 1'b1;
    sel_oe_next = 1'b0;
    case (st_reg)
      bmsr_pkg::st_held:
      begin
        mode_next  = bmsr_pkg::bmsr_decode(sync2_reg[bmsr_pkg::PIN_EPROM],  // R1 R2 R17
                                           sync2_reg[bmsr_pkg::PIN_LINK],
                                           sync2_reg[bmsr_pkg::PIN_SEL_N]);
        link_next  = sync2_reg[bmsr_pkg::PIN_LINK];
        if (!held_pin)
        begin
          if (mode_next == bmsr_pkg::bmsr_mode_eprom ||
              mode_next == bmsr_pkg::bmsr_mode_host)
            st_next = bmsr_pkg::st_boot;  // R6
          else
          begin
            st_next    = bmsr_pkg::st_run;  // R5
            start_next = 1'b1;
            addr_next  = RESET_VECTOR;  // R11
          end
        end
      end
      bmsr_pkg::st_boot:
        if (boot_done)
        begin
          st_next    = bmsr_pkg::st_run;
          start_next = 1'b1;
          addr_next  = RESET_VECTOR;  // R11
        end
      bmsr_pkg::st_run: ;
      default: st_next = bmsr_pkg::st_held;
    endcase
    // pin only ever drives in eprom mode, and only from the bus master
    if (st_reg != bmsr_pkg::st_held && mode_reg == bmsr_pkg::bmsr_mode_eprom &&
        !link_reg && bus_master && !boot_select_float)  // R3 R4 R7
    begin
      sel_oe_next = 1'b1;
      sel_o_next  = !(st_reg == bmsr_pkg::st_boot && boot_cs_request);  // R3
    end
    // reset pin wins over the state and start pulse, not the select drive; known state re-entered
    if (held_pin)
    begin
      st_next    = bmsr_pkg::st_held;  // R11
      start_next = 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      st_reg     <= bmsr_pkg::st_held;
      mode_reg   <= bmsr_pkg::bmsr_mode_none;
      link_reg   <= 1'b0;
      start_reg  <= 1'b0;
      addr_reg   <= '0;
      sel_o_reg  <= 1'b1;
      sel_oe_reg <= 1'b0;
    end
    else
    begin
      st_reg     <= st_next;
      mode_reg   <= mode_next;
      link_reg   <= link_next;
      start_reg  <= start_next;
      addr_reg   <= addr_next;
      sel_o_reg  <= sel_o_next;
      sel_oe_reg <= sel_oe_next;
    end
  end

  // test clock is just another sampled pin; edges become enables
  assign scan.tck_rise = sync2_reg[bmsr_pkg::PIN_TCK] && !tck_prev_reg;  // R14
  assign scan.tck_fall = !sync2_reg[bmsr_pkg::PIN_TCK] && tck_prev_reg;
  assign scan.tms      = sync2_reg[bmsr_pkg::PIN_TMS];
  assign scan.tdi      = sync2_reg[bmsr_pkg::PIN_TDI];
  assign scan.trst_n   = sync2_reg[bmsr_pkg::PIN_TRST_N];
  assign scan.capture_bits = {held_pin, sync2_reg[bmsr_pkg::PIN_EPROM],
                              sync2_reg[bmsr_pkg::PIN_LINK],
                              sync2_reg[bmsr_pkg::PIN_SEL_N], sel_oe_reg,
                              mode_reg, instr_enable};

  bmsr_tap u_tap (
    .clock (clock),
    .rst   (rst),
    .scan  (scan.tap)
  );

  // one instruction slot every clock once running; no divider in the path
  assign instr_enable = (st_reg == bmsr_pkg::st_run);  // R9

  assign boot_memory_select_n_o  = sel_o_reg;
  assign boot_memory_select_n_oe = sel_oe_reg;
  assign boot_mode          = mode_reg;
  assign boot_byte_wide     = (mode_reg == bmsr_pkg::bmsr_mode_eprom);  // R1
  assign boot_active        = (st_reg == bmsr_pkg::st_boot);
  assign core_held          = (st_reg == bmsr_pkg::st_held);
  assign exec_start         = start_reg;
  assign exec_address       = addr_reg;
  assign tdo                = scan.tdo;
  assign tdo_oe             = scan.tdo_oe;
  assign emulation_status_n = 1'b1;  // no emulation engine; status idle
  assign reserved_output    = 1'b0;

  a_sel_eprom_only: assert property (@(posedge clock) disable iff (rst)  // R7
    sel_oe_reg |-> mode_reg == bmsr_pkg::bmsr_mode_eprom && !link_reg)
    else $error("boot select driven outside eprom mode");

  a_sel_master_only: assert property (@(posedge clock) disable iff (rst)  // R4
    sel_oe_reg |-> $past(bus_master) && !$past(boot_select_float))
    else $error("boot select driven without bus mastership");

  a_sel_chip_select: assert property (@(posedge clock) disable iff (rst)  // R3
    st_reg == bmsr_pkg::st_boot && mode_reg == bmsr_pkg::bmsr_mode_eprom && !link_reg
    && bus_master && !boot_select_float && boot_cs_request && !held_pin
    |=> sel_oe_reg && !sel_o_reg)
    else $error("eprom select not asserted");

  a_mode_latched: assert property (@(posedge clock) disable iff (rst)  // R17
    st_reg != bmsr_pkg::st_held |-> $stable(mode_reg))
    else $error("boot mode changed outside reset");

  a_none_runs: assert property (@(posedge clock) disable iff (rst)  // R5
    st_reg == bmsr_pkg::st_held && !held_pin && mode_next == bmsr_pkg::bmsr_mode_none
    |=> st_reg == bmsr_pkg::st_run && exec_start)
    else $error("no boot mode did not start execution");

  a_host_boots: assert property (@(posedge clock) disable iff (rst)  // R6
    st_reg == bmsr_pkg::st_held && !held_pin && mode_next == bmsr_pkg::bmsr_mode_host
    |=> st_reg == bmsr_pkg::st_boot && !exec_start)
    else $error("host mode did not enter boot");

  a_reset_vector: assert property (@(posedge clock) disable iff (rst)  // R11
    exec_start |-> exec_address == RESET_VECTOR && $past(st_reg) != bmsr_pkg::st_run)
    else $error("start not at reset vector");

  a_instr_rate: assert property (@(posedge clock) disable iff (rst)  // R9
    st_reg == bmsr_pkg::st_run && !held_pin ##1 !held_pin |-> instr_enable ##1 instr_enable)
    else $error("instruction slot skipped");

  a_eprom_decode: assert property (@(posedge clock) disable iff (rst)  // R1
    st_reg == bmsr_pkg::st_held && sync2_reg[bmsr_pkg::PIN_EPROM]
    |=> mode_reg == bmsr_pkg::bmsr_mode_eprom)
    else $error("eprom strap not decoded");

  // the engine must report its reset state once test reset has been seen
  a_tap_in_reset: assert property (@(posedge clock) disable iff (rst)  // R13
    !scan.trst_n |=> scan.in_reset)
    else $error("test port reset not reported");

endmodule : bmsr_top

// ===== tb/bmsr_board.sv
/*
  board model: hardwired level behind the boot select pin and a byte wide
  boot eprom loader. assumes the core clock and the dut's boot select pins.
*/
module bmsr_board #(
  parameter int BYTES = 6
)
(
  input  wire logic clock,
  input  wire logic boot_active,
  input  wire logic sel_n_o,
  input  wire logic sel_n_oe,
  input  wire logic strap_level,
  output logic      sel_n_i,
  output logic      boot_cs_request,
  output logic      boot_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int   count    = 0;
  logic req_reg  = 1'b0;
  logic done_reg = 1'b0;

  // released pin falls back to the board resistor, never the last driven value
  assign sel_n_i = sel_n_oe ? sel_n_o : strap_level;

  assign boot_cs_request = req_reg;
  assign boot_done       = done_reg;

  // one byte per cycle, but only while the eprom really sees its select low
  always @(posedge clock)
  begin
    done_reg <= 1'b0;
    if (!boot_active)
    begin
      count <= 0;
      req_reg <= 1'b0;
    end
    else if (count < BYTES)
    begin
      req_reg <= 1'b1;
      if (sel_n_i === 1'b0)
        count <= count + 1;
    end
    else
    begin
      req_reg <= 1'b0;
      done_reg <= (count == BYTES);
      count <= BYTES + 1;
    end
  end
endmodule : bmsr_board

// ===== tb/test_boot_mode_select_reset.sv
/*
  self-checking bench for the boot mode select and reset block.
  assumes a 250 mhz core clock; the board model answers the boot select pin.
*/
module test_boot_mode_select_reset;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] VEC = 32'h00001a40;
  logic clock = 0, rst = 1, prst_n = 0, eb = 0, lb = 0, strap = 1, bm = 1, fl = 0;
  logic hdone = 0, tck = 0, tms = 1, tdi = 0, trst_n = 0;
  logic n_o, n_oe, n_i, req, bdone, bw, active, held, ien, xs, tdo, tdo_oe, status_n, rsv;
  logic [31:0] xa;
  logic [7:0] dout;
  bmsr_pkg::bmsr_mode_t mode;
  bmsr_pkg::bmsr_mode_t notes[$];
  int n_errors = 0, comparisons = 0, seed = 76629;

  bmsr_top #(.ADDR_WIDTH(32), .RESET_VECTOR(VEC)) u_dut (
    .clock(clock), .rst(rst), .processor_reset_n(prst_n), .eprom_boot_strap(eb),
    .link_boot_strap(lb), .boot_memory_select_n_i(n_i), .boot_memory_select_n_o(n_o),
    .boot_memory_select_n_oe(n_oe), .bus_master(bm), .boot_select_float(fl),
    .boot_cs_request(req), .boot_done(bdone | hdone), .boot_mode(mode),
    .boot_byte_wide(bw), .boot_active(active), .core_held(held), .instr_enable(ien),
    .exec_start(xs), .exec_address(xa), .tck(tck), .tms(tms), .tdi(tdi),
    .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .emulation_status_n(status_n),
    .reserved_output(rsv));

  bmsr_board #(.BYTES(6)) u_board (
    .clock(clock), .boot_active(active), .sel_n_o(n_o), .sel_n_oe(n_oe),
    .strap_level(strap), .sel_n_i(n_i), .boot_cs_request(req), .boot_done(bdone));

  // free running core clock, never stopped or slowed
  initial
  begin
    forever #2 clock = ~clock;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  // inputs always move 1 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  task automatic wait_on(ref logic s, input logic v, input int lim);
    for (int i = 0; i < lim && s !== v; i++)
      step(1);
    if (s !== v)
    begin
      check("wait", s, v);
      finish_test();
    end
  endtask : wait_on

  // straps set while reset is low, mode noted, then reset released
  task automatic boot(input logic e, l, s, input bmsr_pkg::bmsr_mode_t m);
    prst_n = 1'b0;
    eb = e;
    lb = l;
    strap = s;
    step(4 + ($random(seed) & 3));
    check("held in reset", {held, ien}, 2'b10);
    notes.push_back(m);
    prst_n = 1'b1;
    wait_on(held, 1'b0, 10);
    check("boot active", active, e | (!l & s));
    check("byte wide", bw, e);
  endtask : boot

  task automatic tpulse(input logic m, d, output logic o);
    tms = m;
    tdi = d;
    step(6);
    tck = 1'b1;
    step(6);
    tck = 1'b0;
    step(6);
    o = tdo;
  endtask : tpulse

  // walk idle to shift, capture first bit, shift n bits, back to idle
  task automatic scan(input logic ir, input logic [7:0] din, input int n);
    logic o;
    tpulse(1'b1, 1'b0, o);
    if (ir)
      tpulse(1'b1, 1'b0, o);
    tpulse(1'b0, 1'b0, o);
    tpulse(1'b0, 1'b0, o);
    dout[0] = o;
    check("tdo enable", tdo_oe, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      tpulse(i == n - 1, din[i], o);
      if (i < 7)
        dout[i + 1] = o;
    end
    tpulse(1'b1, 1'b0, o);
    tpulse(1'b0, 1'b0, o);
  endtask : scan

  // each start pulse is matched against the oldest noted mode
  always @(posedge clock)
  begin
    if (xs === 1'b1)
    begin
      if (notes.size() == 0)
        check("unexpected start", 1'b1, 1'b0);
      else
        check("boot mode", mode, notes.pop_front());
      check("start address", xa, VEC);
    end
  end

  initial
  begin
    logic pb, pf, pr, pa, o;
    step(3);
    rst = 1'b0;
    trst_n = 1'b1;
    check("fixed outputs", {status_n, rsv}, 2'b10);
    boot(1'b0, 1'b0, 1'b0, bmsr_pkg::bmsr_mode_none);
    check("start pulse", {xs, n_oe}, 2'b10);
    step(1);
    check("run", {xs, ien}, 2'b01);
    boot(1'b0, 1'b1, 1'b0, bmsr_pkg::bmsr_mode_reserved);
    wait_on(ien, 1'b1, 3);
    boot(1'b0, 1'b0, 1'b1, bmsr_pkg::bmsr_mode_host);
    step(3);
    check("host pin input", n_oe, 1'b0);
    hdone = 1'b1;
    step(1);
    hdone = 1'b0;
    wait_on(ien, 1'b1, 3);
    boot(1'b1, 1'b1, 1'b1, bmsr_pkg::bmsr_mode_eprom);
    step(3);
    check("link strap blocks drive", n_oe, 1'b0);
    hdone = 1'b1;
    step(1);
    hdone = 1'b0;
    wait_on(ien, 1'b1, 3);
    // eprom boot with random mastership and float requests
    boot(1'b1, 1'b0, 1'b1, bmsr_pkg::bmsr_mode_eprom);
    for (int i = 0; i < 200 && ien !== 1'b1; i++)
    begin
      bm = ($random(seed) % 4) != 0;
      fl = ($random(seed) % 5) == 0;
      pb = bm;
      pf = fl;
      pr = req;
      pa = active;
      step(1);
      check("select enable", n_oe, pb & !pf);
      if (n_oe === 1'b1)
        check("select level", n_o, !(pa & pr));
    end
    wait_on(ien, 1'b1, 1);
    bm = 1'b1;
    fl = 1'b0;
    // test port: reset to idle, then instruction and data scans
    trst_n = 1'b0;
    step(6);
    trst_n = 1'b1;
    tpulse(1'b0, 1'b0, o);
    check("tdo idle", tdo_oe, 1'b0);
    scan(1'b1, {4'h0, bmsr_pkg::IR_SAMPLE}, 4);
    check("ir capture", dout[3:0], bmsr_pkg::IR_CAPTURE);
    scan(1'b0, 8'h00, 8);
    check("boundary capture", dout, 8'h59);
    scan(1'b1, {4'h0, bmsr_pkg::IR_BYPASS}, 4);
    scan(1'b0, 8'h01, 2);
    check("bypass path", dout[2:0], 3'b010);
    // straps move after release: latched mode holds, late done ignored
    eb = 1'b0;
    strap = 1'b0;
    hdone = 1'b1;
    step(1);
    hdone = 1'b0;
    step(5);
    check("mode latched", {mode, ien}, {bmsr_pkg::bmsr_mode_eprom, 1'b1});
    prst_n = 1'b0;
    rst = 1'b1;
    step(3);
    check("reset state", {held, mode, n_oe, xs}, {1'b1, bmsr_pkg::bmsr_mode_none, 2'b00});
    rst = 1'b0;
    step(2);
    check("notes left", notes.size(), 0);
    finish_test();
  end
endmodule : test_boot_mode_select_reset
